//--- design/ictm_pkg.sv
// Behaviour
// - every clock total already contains its read, prefetch and write bus cycles, which are never added on top.
// - each instruction carries separate read, prefetch and write counts, held in that order.
// - a memory bit field spanning five bytes uses two operand accesses, one within four bytes uses one, and the five-byte case has the longer count.
// - memory bit field operations and single and dual compare-and-swap add the calculate-immediate-address time.
// - conditional and loop-decrement branches are complete as listed and take no addressing add-on.
// - a loop-decrement branch, condition false and count not expired, takes 3, 6 or 9 clocks, with two prefetches in the worst case.
// - a loop-decrement branch, condition false and count expired, takes 7, 10 or 10 clocks, with three prefetches in the worst case.
// - a type-1 module call with stack copy takes 63 plus 6 per transfer at best, with 7 plus n reads and 8 plus n writes.
// - a type-1 module call without stack copy takes 48, 50 or 56 clocks with 5 reads and 8 writes.
// - jump and jump-to-subroutine add the jump address time to 1 and 3 clocks at best and 7 and 11 at worst.
// - the single-bound check takes 8 clocks in every case, one prefetch at worst, plus the fetch address time.
// - module calls and the two-bound check add the fetch-immediate time, the two-bound check being 16 or 18 clocks.
// - load and push of an effective address add the calculate address time to 2 and 3 clocks, the push doing one write.
package ictm_pkg;

	localparam int ICTM_TOT_W = 12;
	localparam int ICTM_CNT_W = 8;

	// bus cycle counts, kept in read/prefetch/write order
	typedef struct packed {
		logic [ICTM_TOT_W-1:0] tot;
		logic [ICTM_CNT_W-1:0] rd;
		logic [ICTM_CNT_W-1:0] pf;
		logic [ICTM_CNT_W-1:0] wr;
	} ictm_cnt_t;

	// which addressing add-on an entry takes
	typedef enum logic [2:0] {
		AD_NONE      = 3'h0,
		AD_CALC_IMM  = 3'h1,
		AD_FETCH_IMM = 3'h2,
		AD_JUMP_EA   = 3'h3,
		AD_FETCH_EA  = 3'h4,
		AD_CALC_EA   = 3'h5
	} ictm_addon_t;

	typedef enum logic [1:0] {
		CASE_BEST  = 2'h0,
		CASE_CACHE = 2'h1,
		CASE_WORST = 2'h3
	} ictm_case_t;

	typedef enum logic [1:0] {
		FORM_REG  = 2'h0,
		FORM_MEM4 = 2'h1,
		FORM_MEM5 = 2'h2
	} ictm_form_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RUN  = 2'h1,
		ST_DONE = 2'h3
	} ictm_state_t;

	// bit field ops first, three table rows each; the rest one row each
	typedef enum logic [5:0] {
		field_test_op, field_invert_op, field_clear_op, field_set_op,
		field_extract_signed_op, field_extract_unsigned_op,
		field_insert_op, field_find_first_one_op,
		cond_branch_taken_op, cond_branch_byte_nt_op,
		cond_branch_word_nt_op, cond_branch_long_nt_op,
		loop_decrement_branch_op, loop_decrement_expired_op,
		loop_decrement_true_op,
		and_status_op, xor_status_op, or_status_op,
		and_flags_op, xor_flags_op, or_flags_op,
		branch_subr_op, module_call_t0_op, module_call_op,
		module_call_t1_alt_op, module_call_copy_op,
		compare_swap_ok_op, compare_swap_fail_op,
		dual_compare_swap_op, dual_compare_swap_fail_op,
		single_bound_check_op, two_bound_check_op,
		jump_op, jump_subroutine_op, load_eff_addr_op,
		link_word_op, link_long_op, no_operation_op, push_eff_addr_op,
		return_dealloc_op, module_return_op, module_return_t1_op,
		return_restore_op, return_subr_op, unlink_op
	} ictm_op_t;

	// one table row: totals per case, then r/p/w (prefetch only at worst)
	typedef struct packed {
		logic [ICTM_TOT_W-1:0] tb;
		logic [ICTM_TOT_W-1:0] tc;
		logic [ICTM_TOT_W-1:0] tw;
		logic [ICTM_CNT_W-1:0] rd;
		logic [ICTM_CNT_W-1:0] pf;
		logic [ICTM_CNT_W-1:0] wr;
		ictm_addon_t           ad;
		logic                  per_n;
	} ictm_ent_t;

	localparam int                    ICTM_FIELD_OPS  = 8;
	localparam int                    ICTM_ROWS       = 61;
	localparam logic [5:0]            ICTM_FIELD_ROWS = 6'h18;
	localparam logic [ICTM_TOT_W-1:0] ICTM_PER_N_CLK  = 12'h006;
	localparam logic [ICTM_CNT_W-1:0] ICTM_PER_N_XFER = 8'h01;
	localparam logic [ICTM_TOT_W-1:0] ICTM_TOT_RST    = 12'h000;
	localparam ictm_cnt_t             ICTM_CNT_RST    = '0;

	function automatic ictm_ent_t ent(int tb, int tc, int tw, int r, int p,
			int w, ictm_addon_t ad, logic pn);
		ictm_ent_t e;
		e.tb    = ICTM_TOT_W'(tb);
		e.tc    = ICTM_TOT_W'(tc);
		e.tw    = ICTM_TOT_W'(tw);
		e.rd    = ICTM_CNT_W'(r);
		e.pf    = ICTM_CNT_W'(p);
		e.wr    = ICTM_CNT_W'(w);
		e.ad    = ad;
		e.per_n = pn;
		return e;
	endfunction : ent

	// field op rows: register, memory within four bytes, five bytes
	function automatic logic [5:0] ictm_row(ictm_op_t op, ictm_form_t f);
		logic [5:0] r;
		r = 6'(op);
		if (r < 6'(ICTM_FIELD_OPS)) begin
			r = 6'(r * 6'h03 + 6'(f));
		end else begin
			r = 6'(r - 6'(ICTM_FIELD_OPS) + ICTM_FIELD_ROWS);
		end
		return r;
	endfunction : ictm_row

	localparam ictm_ent_t ICTM_TBL [ICTM_ROWS] = '{
		ent( 3,  6,  7, 0, 1, 0, AD_NONE,      1'b0),
		ent(11, 11, 12, 1, 1, 0, AD_CALC_IMM,  1'b0),
		ent(15, 15, 16, 2, 1, 0, AD_CALC_IMM,  1'b0),
		ent( 9, 12, 12, 0, 1, 0, AD_NONE,      1'b0),
		ent(16, 16, 16, 1, 1, 1, AD_CALC_IMM,  1'b0),
		ent(24, 24, 24, 2, 1, 2, AD_CALC_IMM,  1'b0),
		ent( 9, 12, 12, 0, 1, 0, AD_NONE,      1'b0),
		ent(16, 16, 16, 1, 1, 1, AD_CALC_IMM,  1'b0),
		ent(24, 24, 24, 2, 1, 2, AD_CALC_IMM,  1'b0),
		ent( 9, 12, 12, 0, 1, 0, AD_NONE,      1'b0),
		ent(16, 16, 16, 1, 1, 1, AD_CALC_IMM,  1'b0),
		ent(24, 24, 24, 2, 1, 2, AD_CALC_IMM,  1'b0),
		ent( 5,  8,  8, 0, 1, 0, AD_NONE,      1'b0),
		ent(13, 13, 13, 1, 1, 0, AD_CALC_IMM,  1'b0),
		ent(18, 18, 18, 2, 1, 0, AD_CALC_IMM,  1'b0),
		ent( 5,  8,  8, 0, 1, 0, AD_NONE,      1'b0),
		ent(13, 13, 13, 1, 1, 0, AD_CALC_IMM,  1'b0),
		ent(18, 18, 18, 2, 1, 0, AD_CALC_IMM,  1'b0),
		ent( 7, 10, 10, 0, 1, 0, AD_NONE,      1'b0),
		ent(14, 14, 15, 1, 1, 1, AD_CALC_IMM,  1'b0),
		ent(20, 20, 21, 2, 1, 2, AD_CALC_IMM,  1'b0),
		ent(15, 18, 18, 0, 1, 0, AD_NONE,      1'b0),
		ent(24, 24, 24, 1, 1, 0, AD_CALC_IMM,  1'b0),
		ent(32, 32, 32, 2, 1, 0, AD_CALC_IMM,  1'b0),
		ent( 3,  6,  9, 0, 2, 0, AD_NONE,      1'b0),
		ent( 1,  4,  5, 0, 1, 0, AD_NONE,      1'b0),
		ent( 3,  6,  7, 0, 1, 0, AD_NONE,      1'b0),
		ent( 3,  6,  9, 0, 2, 0, AD_NONE,      1'b0),
		ent( 3,  6,  9, 0, 2, 0, AD_NONE,      1'b0),
		ent( 7, 10, 10, 0, 3, 0, AD_NONE,      1'b0),
		ent( 3,  6,  7, 0, 1, 0, AD_NONE,      1'b0),
		ent( 9, 12, 15, 0, 2, 0, AD_NONE,      1'b0),
		ent( 9, 12, 15, 0, 2, 0, AD_NONE,      1'b0),
		ent( 9, 12, 15, 0, 2, 0, AD_NONE,      1'b0),
		ent( 9, 12, 15, 0, 2, 0, AD_NONE,      1'b0),
		ent( 9, 12, 15, 0, 2, 0, AD_NONE,      1'b0),
		ent( 9, 12, 15, 0, 2, 0, AD_NONE,      1'b0),
		ent( 5,  7, 13, 0, 2, 1, AD_NONE,      1'b0),
		ent(28, 30, 36, 2, 2, 6, AD_FETCH_IMM, 1'b0),
		ent(48, 50, 56, 5, 2, 8, AD_FETCH_IMM, 1'b0),
		ent(55, 57, 64, 6, 2, 8, AD_FETCH_IMM, 1'b0),
		ent(63, 65, 71, 7, 2, 8, AD_FETCH_IMM, 1'b1),
		ent(15, 15, 16, 1, 1, 1, AD_CALC_IMM,  1'b0),
		ent(12, 12, 13, 1, 1, 0, AD_CALC_IMM,  1'b0),
		ent(23, 25, 28, 2, 2, 2, AD_CALC_IMM,  1'b0),
		ent(19, 22, 25, 2, 2, 0, AD_CALC_IMM,  1'b0),
		ent( 8,  8,  8, 0, 1, 0, AD_FETCH_EA,  1'b0),
		ent(16, 18, 18, 2, 1, 0, AD_FETCH_IMM, 1'b0),
		ent( 1,  4,  7, 0, 2, 0, AD_JUMP_EA,   1'b0),
		ent( 3,  5, 11, 0, 2, 1, AD_JUMP_EA,   1'b0),
		ent( 2,  2,  3, 0, 1, 0, AD_CALC_EA,   1'b0),
		ent( 3,  5,  7, 0, 1, 1, AD_NONE,      1'b0),
		ent( 4,  6, 10, 0, 2, 1, AD_NONE,      1'b0),
		ent( 2,  2,  3, 0, 1, 0, AD_NONE,      1'b0),
		ent( 3,  5,  6, 0, 1, 1, AD_CALC_EA,   1'b0),
		ent( 9, 10, 12, 1, 2, 0, AD_NONE,      1'b0),
		ent(18, 19, 22, 4, 2, 0, AD_NONE,      1'b0),
		ent(31, 32, 35, 6, 2, 1, AD_NONE,      1'b0),
		ent(13, 14, 15, 2, 2, 0, AD_NONE,      1'b0),
		ent( 9, 10, 12, 1, 2, 0, AD_NONE,      1'b0),
		ent( 5,  6,  7, 1, 1, 0, AD_NONE,      1'b0)
	};

endpackage : ictm_pkg

//--- design/ictm_lookup.sv
`timescale 1ns/1ps
module ictm_lookup
	import ictm_pkg::*;
#(
	parameter int N_W = 6
) (
	// instruction and its context
	input  wire ictm_op_t   op,
	input  wire ictm_form_t form,
	input  wire ictm_case_t sel,
	input  wire [N_W-1:0]   n_xfer,
	// addressing add-on times
	input  wire ictm_cnt_t  calc_imm_time,
	input  wire ictm_cnt_t  fetch_imm_time,
	input  wire ictm_cnt_t  jump_ea_time,
	input  wire ictm_cnt_t  fetch_ea_time,
	input  wire ictm_cnt_t  calc_ea_time,
	// resulting cost
	output ictm_cnt_t       cost
);

	wire [5:0]             row;
	ictm_ent_t             e;
	ictm_cnt_t             addon;
	wire [ICTM_TOT_W-1:0]  base_tot;
	wire [ICTM_CNT_W-1:0]  base_pf;
	wire [ICTM_TOT_W-1:0]  n_tot;
	wire [ICTM_CNT_W-1:0]  n_cnt;

	// row select and entry fetch
	assign row = ictm_row(op, form);
	assign e   = ICTM_TBL[row];

	// add-on mux; branch rows carry AD_NONE so nothing is added
	assign addon = (e.ad == AD_CALC_IMM)  ? calc_imm_time :
	               (e.ad == AD_FETCH_IMM) ? fetch_imm_time :
	               (e.ad == AD_JUMP_EA)   ? jump_ea_time :
	               (e.ad == AD_FETCH_EA)  ? fetch_ea_time :
	               (e.ad == AD_CALC_EA)   ? calc_ea_time :
	               ICTM_CNT_RST;

	// case choice; row prefetches only show in the worst case, add-on prefetches in every case
	assign base_tot = (sel == CASE_BEST)  ? e.tb :
	                  (sel == CASE_CACHE) ? e.tc : e.tw;
	assign base_pf  = (sel == CASE_WORST) ? e.pf : '0;

	// per-transfer terms of the stack copy call
	assign n_tot = e.per_n ? ICTM_TOT_W'(ICTM_TOT_W'(n_xfer) * ICTM_PER_N_CLK)
	                       : ICTM_TOT_RST;
	assign n_cnt = e.per_n ? ICTM_CNT_W'(ICTM_CNT_W'(n_xfer) * ICTM_PER_N_XFER)
	                       : '0;

	// totals include bus cycles; r/p/w are reported, not added again
	assign cost.tot = ICTM_TOT_W'(base_tot + n_tot + addon.tot);
	assign cost.rd  = ICTM_CNT_W'(e.rd + n_cnt + addon.rd);
	assign cost.pf  = ICTM_CNT_W'(base_pf + addon.pf);
	assign cost.wr  = ICTM_CNT_W'(e.wr + n_cnt + addon.wr);

endmodule : ictm_lookup

//--- design/ictm_timing.sv
`timescale 1ns/1ps
module ictm_timing
	import ictm_pkg::*;
#(
	parameter int N_W = 6
) (
	// clock and reset
	input  wire                  clk,
	input  wire                  sys_rst,
	// instruction request
	input  wire                  req_valid,
	input  wire ictm_op_t        req_op,
	input  wire                  req_mem,
	input  wire                  req_span5,
	input  wire [N_W-1:0]        req_n,
	// fetch and cache status for this instruction
	input  wire                  pf_overlap,
	input  wire                  cache_hit,
	// addressing add-on times
	input  wire ictm_cnt_t       calc_imm_time,
	input  wire ictm_cnt_t       fetch_imm_time,
	input  wire ictm_cnt_t       jump_ea_time,
	input  wire ictm_cnt_t       fetch_ea_time,
	input  wire ictm_cnt_t       calc_ea_time,
	// execution status and result
	output logic                 req_ready_ff,
	output logic                 busy_ff,
	output logic                 done_ff,
	output ictm_case_t           case_ff,
	output ictm_cnt_t            result_ff
);

	ictm_state_t           state_ff;
	ictm_state_t           nxt_state;
	logic [ICTM_TOT_W-1:0] remain_ff;
	logic [ICTM_TOT_W-1:0] nxt_remain;
	ictm_cnt_t             nxt_result;
	ictm_case_t            nxt_case;
	wire                   accept;
	wire                   last_clk;
	ictm_form_t            form;
	ictm_cnt_t             cost;

	// request taken only while idle
	assign accept   = req_valid & req_ready_ff;
	assign last_clk = (remain_ff <= 12'h001);

	// five-byte field needs the two-access row
	assign form = !req_mem   ? FORM_REG :
	              req_span5  ? FORM_MEM5 : FORM_MEM4;

	// overlap hides fetch time, else cache hit beats worst
	assign nxt_case = pf_overlap ? CASE_BEST :
	                  cache_hit  ? CASE_CACHE : CASE_WORST;

	ictm_lookup #(
		.N_W (N_W)
	) u_lookup (
		.op             (req_op),
		.form           (form),
		.sel            (nxt_case),
		.n_xfer         (req_n),
		.calc_imm_time  (calc_imm_time),
		.fetch_imm_time (fetch_imm_time),
		.jump_ea_time   (jump_ea_time),
		.fetch_ea_time  (fetch_ea_time),
		.calc_ea_time   (calc_ea_time),
		.cost           (cost)
	);

	// sequencing: the busy span is the reported total, bus cycles included
	always_comb begin
		nxt_state  = state_ff;
		nxt_remain = remain_ff;
		nxt_result = result_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (accept) begin
					nxt_state  = ST_RUN;
					nxt_remain = cost.tot;
					nxt_result = cost;
				end
			end
			ST_RUN: begin
				nxt_remain = ICTM_TOT_W'(remain_ff - 12'h001);
				if (last_clk) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// state and counter
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff  <= ST_IDLE;
			remain_ff <= ICTM_TOT_RST;
			result_ff <= ICTM_CNT_RST;
		end else begin
			state_ff  <= nxt_state;
			remain_ff <= nxt_remain;
			result_ff <= nxt_result;
		end
	end

	// status flags registered from next state so outputs stay glitch free
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			req_ready_ff <= 1'b1;
			busy_ff      <= 1'b0;
			done_ff      <= 1'b0;
			case_ff      <= CASE_BEST;
		end else begin
			req_ready_ff <= (nxt_state == ST_IDLE);
			busy_ff      <= (nxt_state == ST_RUN);
			done_ff      <= (nxt_state == ST_DONE);
			if (accept) begin
				case_ff <= nxt_case;
			end
		end
	end

	// helper: length of the busy span, only read by checks
	logic [ICTM_TOT_W-1:0] run_len_ff;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_len_ff <= ICTM_TOT_RST;
		end else if (accept) begin
			run_len_ff <= ICTM_TOT_RST;
		end else if (busy_ff) begin
			run_len_ff <= ICTM_TOT_W'(run_len_ff + 12'h001);
		end
	end

	property p_span_total;
		@(posedge clk) disable iff (sys_rst)
		$rose(done_ff) |-> run_len_ff == result_ff.tot;
	endproperty
	a_span_total: assert property (p_span_total)
		else $error("busy span differs from reported total");

	property p_reg_field_no_bus;
		@(posedge clk) disable iff (sys_rst)
		accept && !req_mem && req_op == field_set_op
		|=> result_ff.rd == 8'h00 && result_ff.wr == 8'h00;
	endproperty
	a_reg_field_no_bus: assert property (p_reg_field_no_bus)
		else $error("register field op shows operand cycles");

	property p_span5_two_reads;
		@(posedge clk) disable iff (sys_rst)
		accept && req_mem && req_span5 && req_op == field_test_op
		|=> result_ff.rd == 8'(8'h02 + $past(calc_imm_time.rd));
	endproperty
	a_span5_two_reads: assert property (p_span5_two_reads)
		else $error("five byte field not two reads");

	property p_span4_one_read;
		@(posedge clk) disable iff (sys_rst)
		accept && req_mem && !req_span5 && req_op == field_insert_op
		|=> result_ff.rd == 8'(8'h01 + $past(calc_imm_time.rd))
		 && result_ff.wr == 8'(8'h01 + $past(calc_imm_time.wr));
	endproperty
	a_span4_one_read: assert property (p_span4_one_read)
		else $error("four byte field not one access");

	property p_dual_swap_addon;
		@(posedge clk) disable iff (sys_rst)
		accept && pf_overlap && req_op == dual_compare_swap_op
		|=> result_ff.tot == 12'(12'h017 + $past(calc_imm_time.tot));
	endproperty
	a_dual_swap_addon: assert property (p_dual_swap_addon)
		else $error("dual swap missing immediate time");

	property p_branch_no_addon;
		@(posedge clk) disable iff (sys_rst)
		accept && !pf_overlap && !cache_hit
		&& req_op == cond_branch_taken_op
		|=> result_ff.tot == 12'h009 && result_ff.pf == 8'h02;
	endproperty
	a_branch_no_addon: assert property (p_branch_no_addon)
		else $error("branch total not complete as listed");

	property p_loop_not_expired;
		@(posedge clk) disable iff (sys_rst)
		accept && !pf_overlap && !cache_hit
		&& req_op == loop_decrement_branch_op
		|=> result_ff.tot == 12'h009 && result_ff.pf == 8'h02
		##1 busy_ff [*8] ##1 done_ff;
	endproperty
	a_loop_not_expired: assert property (p_loop_not_expired)
		else $error("loop branch not expired wrong");

	property p_loop_expired;
		@(posedge clk) disable iff (sys_rst)
		accept && !pf_overlap && cache_hit
		&& req_op == loop_decrement_expired_op
		|=> result_ff.tot == 12'h00a && case_ff == CASE_CACHE;
	endproperty
	a_loop_expired: assert property (p_loop_expired)
		else $error("loop branch expired wrong");

	property p_call_copy;
		@(posedge clk) disable iff (sys_rst)
		accept && pf_overlap && req_op == module_call_copy_op
		|=> result_ff.tot == 12'(12'h03f + 12'h006 * 12'($past(req_n))
		    + $past(fetch_imm_time.tot))
		 && result_ff.wr == 8'(8'h08 + 8'($past(req_n))
		    + $past(fetch_imm_time.wr));
	endproperty
	a_call_copy: assert property (p_call_copy)
		else $error("stack copy call count wrong");

	property p_call_no_copy;
		@(posedge clk) disable iff (sys_rst)
		accept && !pf_overlap && !cache_hit && req_op == module_call_op
		|=> result_ff.tot == 12'(12'h038 + $past(fetch_imm_time.tot))
		 && result_ff.rd == 8'(8'h05 + $past(fetch_imm_time.rd));
	endproperty
	a_call_no_copy: assert property (p_call_no_copy)
		else $error("call without copy wrong");

	property p_jump_sub;
		@(posedge clk) disable iff (sys_rst)
		accept && !pf_overlap && !cache_hit
		&& req_op == jump_subroutine_op
		|=> result_ff.tot == 12'(12'h00b + $past(jump_ea_time.tot));
	endproperty
	a_jump_sub: assert property (p_jump_sub)
		else $error("jump subroutine total wrong");

	property p_single_check;
		@(posedge clk) disable iff (sys_rst)
		accept && req_op == single_bound_check_op
		|=> result_ff.tot == 12'(12'h008 + $past(fetch_ea_time.tot));
	endproperty
	a_single_check: assert property (p_single_check)
		else $error("single bound check not eight");

	property p_two_check;
		@(posedge clk) disable iff (sys_rst)
		accept && pf_overlap && req_op == two_bound_check_op
		|=> result_ff.tot == 12'(12'h010 + $past(fetch_imm_time.tot));
	endproperty
	a_two_check: assert property (p_two_check)
		else $error("two bound check total wrong");

	property p_push_addr;
		@(posedge clk) disable iff (sys_rst)
		accept && pf_overlap && req_op == push_eff_addr_op
		|=> result_ff.tot == 12'(12'h003 + $past(calc_ea_time.tot))
		 && result_ff.wr == 8'(8'h01 + $past(calc_ea_time.wr));
	endproperty
	a_push_addr: assert property (p_push_addr)
		else $error("push address count wrong");

	property p_case_overlap;
		@(posedge clk) disable iff (sys_rst)
		accept && pf_overlap |=> case_ff == CASE_BEST && busy_ff;
	endproperty
	a_case_overlap: assert property (p_case_overlap)
		else $error("overlap did not select best case");

endmodule : ictm_timing

//--- bench/ictm_fetch_model.sv
`timescale 1ns/1ps
module ictm_fetch_model
	import ictm_pkg::*;
(
	// fetch status selector: 0 overlapped, 1 cache hit, 2 miss
	input  wire [1:0] mode,
	// per-instruction fetch status
	output logic      pf_overlap,
	output logic      cache_hit,
	// addressing add-on times
	output ictm_cnt_t calc_imm_time,
	output ictm_cnt_t fetch_imm_time,
	output ictm_cnt_t jump_ea_time,
	output ictm_cnt_t fetch_ea_time,
	output ictm_cnt_t calc_ea_time
);
	// hit stays high while overlapped, so the priority is exercised
	assign pf_overlap = (mode == 2'h0);
	assign cache_hit  = (mode != 2'h2);

	// distinct add-on figures so a wrongly chosen add-on shows up
	assign calc_imm_time  = '{12'h004, 8'h01, 8'h00, 8'h00};
	assign fetch_imm_time = '{12'h005, 8'h00, 8'h01, 8'h00};
	assign jump_ea_time   = '{12'h002, 8'h00, 8'h00, 8'h00};
	assign fetch_ea_time  = '{12'h003, 8'h01, 8'h00, 8'h00};
	assign calc_ea_time   = '{12'h001, 8'h00, 8'h00, 8'h00};
endmodule : ictm_fetch_model

//--- bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin \
	mismatches++; $display("MISMATCH %0t %s", $time, m); end end
module tb_top
	import ictm_pkg::*;
;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       req_valid = 1'b0;
	ictm_op_t   req_op = no_operation_op;
	logic       req_mem = 1'b0;
	logic       req_span5 = 1'b0;
	logic [5:0] req_n = 6'h00;
	logic [1:0] mode = 2'h0;
	logic       pf_overlap, cache_hit, req_ready_ff, busy_ff, done_ff;
	ictm_cnt_t  t_ci, t_fi, t_je, t_fe, t_ce, result_ff;
	ictm_case_t case_ff;
	int         mismatches = 0;
	int         n_compared = 0;

	always #2 clk = ~clk;

	ictm_fetch_model ictm_fetch_model_inst (.mode(mode),
		.pf_overlap(pf_overlap), .cache_hit(cache_hit),
		.calc_imm_time(t_ci), .fetch_imm_time(t_fi),
		.jump_ea_time(t_je), .fetch_ea_time(t_fe), .calc_ea_time(t_ce));

	ictm_timing #(.N_W(6)) ictm_timing_inst (.clk(clk), .sys_rst(sys_rst),
		.req_valid(req_valid), .req_op(req_op), .req_mem(req_mem),
		.req_span5(req_span5), .req_n(req_n), .pf_overlap(pf_overlap),
		.cache_hit(cache_hit), .calc_imm_time(t_ci),
		.fetch_imm_time(t_fi), .jump_ea_time(t_je), .fetch_ea_time(t_fe),
		.calc_ea_time(t_ce), .req_ready_ff(req_ready_ff),
		.busy_ff(busy_ff), .done_ff(done_ff), .case_ff(case_ff),
		.result_ff(result_ff));

	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	task give_up;
		mismatches++;
		$display("MISMATCH %0t wait ran out", $time);
		complete_run();
	endtask : give_up

	function automatic ictm_cnt_t cnt_of(int t, int r, int p, int w);
		return '{ICTM_TOT_W'(t), ICTM_CNT_W'(r), ICTM_CNT_W'(p),
			ICTM_CNT_W'(w)};
	endfunction : cnt_of

	// one whole transfer: wait idle, request, check answer, time busy
	task run_op(ictm_op_t op, logic mem, logic s5, logic [5:0] n,
			logic [1:0] m, ictm_cnt_t exp, ictm_case_t ec);
		int k;
		k = 0;
		while (req_ready_ff !== 1'b1 && k < 600) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k >= 600) give_up();
		req_op = op;
		req_mem = mem;
		req_span5 = s5;
		req_n = n;
		mode = m;
		req_valid = 1'b1;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		`CHK(result_ff, exp, "result counts")
		`CHK(case_ff, ec, "case chosen")
		`CHK(busy_ff, 1'b1, "busy at answer")
		k = 1;
		while (busy_ff === 1'b1 && k < 600) begin
			@(posedge clk);
			#1;
			if (busy_ff === 1'b1) k++;
		end
		if (busy_ff === 1'b1) give_up();
		`CHK(12'(k), exp.tot, "busy length")
		`CHK(done_ff, 1'b1, "done pulse")
		`CHK(req_ready_ff, 1'b0, "ready during done")
	endtask : run_op

	task t_loop;
		run_op(loop_decrement_branch_op, 0, 0, 0, 2, cnt_of(9, 0, 2, 0),
			CASE_WORST);
		run_op(loop_decrement_branch_op, 0, 0, 0, 0, cnt_of(3, 0, 0, 0),
			CASE_BEST);
		run_op(loop_decrement_branch_op, 0, 0, 0, 1, cnt_of(6, 0, 0, 0),
			CASE_CACHE);
		run_op(loop_decrement_expired_op, 0, 0, 0, 2, cnt_of(10, 0, 3, 0),
			CASE_WORST);
		run_op(loop_decrement_expired_op, 0, 0, 0, 0, cnt_of(7, 0, 0, 0),
			CASE_BEST);
		run_op(loop_decrement_expired_op, 0, 0, 0, 1, cnt_of(10, 0, 0, 0),
			CASE_CACHE);
		$display("test loop branch done");
	endtask : t_loop

	// five-byte best totals and writes of the eight field ops, in order
	task t_field;
		int fb [8] = '{15, 24, 24, 24, 18, 18, 20, 32};
		int fw [8] = '{0, 2, 2, 2, 0, 0, 2, 0};
		for (int i = 0; i < 8; i++) begin
			run_op(ictm_op_t'(i), 1, 1, 0, 0, cnt_of(fb[i] + 4, 3, 0, fw[i]),
				CASE_BEST);
		end
		run_op(field_test_op, 0, 1, 0, 0, cnt_of(3, 0, 0, 0),
			CASE_BEST);
		run_op(field_test_op, 1, 0, 0, 2, cnt_of(16, 2, 1, 0),
			CASE_WORST);
		run_op(field_test_op, 1, 1, 0, 2, cnt_of(20, 3, 1, 0),
			CASE_WORST);
		$display("test bit field done");
	endtask : t_field

	task t_call;
		run_op(module_call_op, 0, 0, 0, 0, cnt_of(53, 5, 1, 8),
			CASE_BEST);
		run_op(module_call_op, 0, 0, 0, 2, cnt_of(61, 5, 3, 8),
			CASE_WORST);
		run_op(module_call_copy_op, 0, 0, 6'h03, 0, cnt_of(86, 10, 1, 11),
			CASE_BEST);
		run_op(module_call_copy_op, 0, 0, 6'h00, 0, cnt_of(68, 7, 1, 8),
			CASE_BEST);
		run_op(module_call_copy_op, 0, 0, 6'h3f, 2, cnt_of(454, 70, 3, 71),
			CASE_WORST);
		$display("test module call done");
	endtask : t_call

	task t_misc;
		run_op(jump_op, 0, 0, 0, 0, cnt_of(3, 0, 0, 0), CASE_BEST);
		run_op(jump_op, 0, 0, 0, 2, cnt_of(9, 0, 2, 0), CASE_WORST);
		run_op(jump_subroutine_op, 0, 0, 0, 2, cnt_of(13, 0, 2, 1),
			CASE_WORST);
		run_op(single_bound_check_op, 0, 0, 0, 0, cnt_of(11, 1, 0, 0),
			CASE_BEST);
		run_op(single_bound_check_op, 0, 0, 0, 2, cnt_of(11, 1, 1, 0),
			CASE_WORST);
		run_op(two_bound_check_op, 0, 0, 0, 0, cnt_of(21, 2, 1, 0),
			CASE_BEST);
		run_op(two_bound_check_op, 0, 0, 0, 1, cnt_of(23, 2, 1, 0),
			CASE_CACHE);
		run_op(load_eff_addr_op, 0, 0, 0, 0, cnt_of(3, 0, 0, 0),
			CASE_BEST);
		run_op(push_eff_addr_op, 0, 0, 0, 0, cnt_of(4, 0, 0, 1),
			CASE_BEST);
		run_op(dual_compare_swap_op, 0, 0, 0, 0, cnt_of(27, 3, 0, 2),
			CASE_BEST);
		$display("test control done");
	endtask : t_misc

	// remaining rows, so every decoded op is reached at least once
	task t_other;
		run_op(field_set_op, 0, 0, 0, 2, cnt_of(12, 0, 1, 0),
			CASE_WORST);
		run_op(field_insert_op, 1, 0, 0, 0, cnt_of(18, 2, 0, 1),
			CASE_BEST);
		run_op(cond_branch_taken_op, 0, 0, 0, 2, cnt_of(9, 0, 2, 0),
			CASE_WORST);
		run_op(cond_branch_byte_nt_op, 0, 0, 0, 0, cnt_of(1, 0, 0, 0),
			CASE_BEST);
		run_op(cond_branch_word_nt_op, 0, 0, 0, 1, cnt_of(6, 0, 0, 0),
			CASE_CACHE);
		run_op(cond_branch_long_nt_op, 0, 0, 0, 2, cnt_of(9, 0, 2, 0),
			CASE_WORST);
		run_op(loop_decrement_true_op, 0, 0, 0, 2, cnt_of(7, 0, 1, 0),
			CASE_WORST);
		for (int i = 0; i < 6; i++) begin
			run_op(ictm_op_t'(int'(and_status_op) + i), 0, 0, 0, 1,
				cnt_of(12, 0, 0, 0), CASE_CACHE);
		end
		run_op(branch_subr_op, 0, 0, 0, 2, cnt_of(13, 0, 2, 1),
			CASE_WORST);
		run_op(module_call_t0_op, 0, 0, 0, 1, cnt_of(35, 2, 1, 6),
			CASE_CACHE);
		run_op(module_call_t1_alt_op, 0, 0, 0, 0, cnt_of(60, 6, 1, 8),
			CASE_BEST);
		run_op(compare_swap_ok_op, 0, 0, 0, 2, cnt_of(20, 2, 1, 1),
			CASE_WORST);
		run_op(compare_swap_fail_op, 0, 0, 0, 0, cnt_of(16, 2, 0, 0),
			CASE_BEST);
		run_op(dual_compare_swap_fail_op, 0, 0, 0, 1, cnt_of(26, 3, 0, 0),
			CASE_CACHE);
		run_op(link_word_op, 0, 0, 0, 1, cnt_of(5, 0, 0, 1),
			CASE_CACHE);
		run_op(link_long_op, 0, 0, 0, 2, cnt_of(10, 0, 2, 1),
			CASE_WORST);
		run_op(no_operation_op, 0, 0, 0, 0, cnt_of(2, 0, 0, 0),
			CASE_BEST);
		run_op(return_dealloc_op, 0, 0, 0, 2, cnt_of(12, 1, 2, 0),
			CASE_WORST);
		run_op(module_return_op, 0, 0, 0, 0, cnt_of(18, 4, 0, 0),
			CASE_BEST);
		run_op(module_return_t1_op, 0, 0, 0, 2, cnt_of(35, 6, 2, 1),
			CASE_WORST);
		run_op(return_restore_op, 0, 0, 0, 1, cnt_of(14, 2, 0, 0),
			CASE_CACHE);
		run_op(return_subr_op, 0, 0, 0, 1, cnt_of(10, 1, 0, 0),
			CASE_CACHE);
		run_op(unlink_op, 0, 0, 0, 2, cnt_of(7, 1, 1, 0),
			CASE_WORST);
		$display("test other rows done");
	endtask : t_other

	// reset held six cycles, then idle values checked before traffic
	initial begin
		repeat (6) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		`CHK(req_ready_ff, 1'b1, "ready after reset")
		`CHK(busy_ff, 1'b0, "busy after reset")
		`CHK(result_ff, ICTM_CNT_RST, "result after reset")
		t_loop();
		t_field();
		t_call();
		t_misc();
		t_other();
		complete_run();
	end
endmodule : tb_top
